//--- hw/lpddr_burst_mode.sv
// Notes on behaviour
// RULE1: Burst lengths two, four and eight work for both ordering types.
// RULE2: Optional sixteen-long burst uses four start-offset bits.
// RULE3: Length two: column A1 up picks block, A0 picks start.
// RULE4: Length four: column A2 up picks block, A0-A1 pick start.
// RULE5: Length eight: column A3 up picks block, A0-A2 pick start.
// RULE6: Length sixteen: column A4 up picks block, A0-A3 pick start.
// RULE7: Burst columns wrap inside the selected block, never crossing it.
// RULE8: Sequential order adds one per element modulo burst length.
// RULE9: Mode bit A3 picks type; interleaved offset is start XOR count.
// RULE10: One programmed burst length serves reads and writes alike.
// RULE11: Latency three gives first read data two clocks after command.
// RULE12: Optional latency two gives one clock, four gives three clocks.
// RULE13: Extended register written with high bank bit set, kept till rewritten; the logic here also clears it on deep power-down.
// RULE14: Controller loads extended register only when idle, then waits.
// RULE15: Extended bits A0-A2 refresh region, A3-A4 temp setting, A5-A7 drive.
// RULE16: Controller writes zero on undefined mode address bits.
// RULE17: Region and temperature settings act only during self refresh.
// RULE18: Controller never programs reserved field encodings.
// RULE19: Base register A0-A2 length, A3 type, A4-A6 read latency.
// RULE20: Outside the reduced region data may be lost in self refresh.
// RULE21: All commands sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module lpddr_burst_mode #(
    parameter bit SUPPORT_BL16 = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic        bank_sel_low,
    input  wire logic        bank_sel_high,
    input  wire logic [12:0] addr,
    input  wire logic        self_refresh,
    input  wire logic        deep_power_down,
    output logic      [9:0]  burst_col,
    output logic             burst_valid,
    output logic             burst_is_write,
    output logic             rd_first_data,
    output logic      [2:0]  partial_refresh_region,
    output logic      [1:0]  temp_comp_refresh_setting,
    output logic      [2:0]  drive_strength
);
    localparam int CW = lpddr_cfg_pkg::COL_W;

    logic [12:0] mode_reg;
    logic [12:0] extended_mode_config_reg;
    logic [CW-1:0] block_reg;
    logic [3:0]  start_reg;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [2:0]  rd_pipe_reg;
    logic        write_reg;
    lpddr_cfg_pkg::burst_state_t state_reg;

    // Command decode, all sampled on the rising clock edge
    wire       cmd_mode  = !cs_n && !ras_n && !cas_n && !we_n; // RULE21
    wire       cmd_col   = !cs_n && ras_n && !cas_n;
    wire       cmd_rd    = cmd_col && we_n;
    wire [1:0] bank      = {bank_sel_high, bank_sel_low};
    wire       load_base = cmd_mode && bank == lpddr_cfg_pkg::BANK_BASE_MODE;
    wire       load_ext  = cmd_mode && bank == lpddr_cfg_pkg::BANK_EXT_MODE;

    // Mode fields
    wire [2:0] bl_code = mode_reg[lpddr_cfg_pkg::BL_LSB +: 3]; // RULE19
    wire [2:0] cl_code = mode_reg[lpddr_cfg_pkg::CL_LSB +: 3]; // RULE19
    wire       interleaved = mode_reg[lpddr_cfg_pkg::BT_BIT]; // RULE9

    // Offset mask from the one shared burst length
    wire [3:0] off_mask =                                      // RULE10
        (bl_code == lpddr_cfg_pkg::BL_CODE_2) ? lpddr_cfg_pkg::OFF_MASK_2 :
        (bl_code == lpddr_cfg_pkg::BL_CODE_4) ? lpddr_cfg_pkg::OFF_MASK_4 :
        (bl_code == lpddr_cfg_pkg::BL_CODE_8) ? lpddr_cfg_pkg::OFF_MASK_8 :
        (bl_code == lpddr_cfg_pkg::BL_CODE_16 && SUPPORT_BL16) ?
            lpddr_cfg_pkg::OFF_MASK_16 : 4'h0; // RULE1 RULE2
    wire          bl_ok    = off_mask != 4'h0;
    wire [CW-1:0] col_mask = {{(CW-4){1'b0}}, off_mask};

    // Block select from upper bits, start offset from lower bits
    // RULE3 RULE4 RULE5 RULE6
    wire [CW-1:0] cmd_block = addr[CW-1:0] & ~col_mask;
    wire [3:0]    cmd_start = addr[3:0] & off_mask;

    // Element offset: sequential sum or interleaved XOR, wrapped in block
    assign cnt_next = cnt_reg + 4'h1;
    wire [3:0] off_seq = 4'(start_reg + cnt_next) & off_mask; // RULE8 RULE7
    wire [3:0] off_int = (start_reg ^ cnt_next) & off_mask;   // RULE9 RULE7
    wire [3:0] off_nxt = interleaved ? off_int : off_seq;
    wire       last    = cnt_reg == off_mask;

    // Mode registers; deep power-down drops their contents
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg                 <= lpddr_cfg_pkg::MODE_RST;
            extended_mode_config_reg <= lpddr_cfg_pkg::EXT_RST;
        end else if (deep_power_down) begin
            mode_reg                 <= lpddr_cfg_pkg::MODE_RST;
            extended_mode_config_reg <= lpddr_cfg_pkg::EXT_RST; // RULE13
        end else begin
            if (load_base)
                mode_reg <= addr;
            if (load_ext)
                extended_mode_config_reg <= addr; // RULE13
        end
    end

    // Burst column sequencer; a new column command restarts it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= lpddr_cfg_pkg::BURST_IDLE;
            block_reg <= '0;
            start_reg <= 4'h0;
            cnt_reg   <= 4'h0;
            write_reg <= 1'b0;
            burst_col <= '0;
        end else if (deep_power_down) begin
            state_reg <= lpddr_cfg_pkg::BURST_IDLE;
        end else if (cmd_col && bl_ok) begin
            state_reg <= lpddr_cfg_pkg::BURST_RUN;
            block_reg <= cmd_block;
            start_reg <= cmd_start;
            cnt_reg   <= 4'h0;
            write_reg <= !we_n;
            burst_col <= cmd_block | {{(CW-4){1'b0}}, cmd_start};
        end else begin
            case (state_reg)
                lpddr_cfg_pkg::BURST_RUN: begin
                    if (last) begin
                        state_reg <= lpddr_cfg_pkg::BURST_IDLE;
                    end else begin
                        cnt_reg   <= cnt_next;
                        burst_col <= block_reg |
                                     {{(CW-4){1'b0}}, off_nxt}; // RULE7
                    end
                end
                default: state_reg <= lpddr_cfg_pkg::BURST_IDLE;
            endcase
        end
    end

    assign burst_valid    = state_reg == lpddr_cfg_pkg::BURST_RUN;
    assign burst_is_write = write_reg;

    // Read latency pipe; first data marks latency minus one clocks later
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            rd_pipe_reg <= 3'h0;
        else
            rd_pipe_reg <= {rd_pipe_reg[1:0], cmd_rd && bl_ok};
    end

    assign rd_first_data =
        (cl_code == lpddr_cfg_pkg::CL_CODE_2) ? rd_pipe_reg[0] : // RULE12
        (cl_code == lpddr_cfg_pkg::CL_CODE_3) ? rd_pipe_reg[1] : // RULE11
        (cl_code == lpddr_cfg_pkg::CL_CODE_4) ? rd_pipe_reg[2] : // RULE12
        1'b0;

    // Extended fields; refresh settings only reach the core in self refresh
    wire [2:0] region_f =
        extended_mode_config_reg[lpddr_cfg_pkg::REGION_LSB +: 3];
    wire [1:0] temp_f =
        extended_mode_config_reg[lpddr_cfg_pkg::TEMP_LSB +: 2];
    assign partial_refresh_region    = self_refresh ? region_f : // RULE20
                                       lpddr_cfg_pkg::REGION_OFF; // RULE17
    assign temp_comp_refresh_setting = self_refresh ? temp_f :
                                       lpddr_cfg_pkg::TEMP_OFF; // RULE17
    assign drive_strength =
        extended_mode_config_reg[lpddr_cfg_pkg::DRV_LSB +: 3]; // RULE15

    // Checks
    property p_base_load;
        @(posedge clk) disable iff (sys_rst)
        load_base && !deep_power_down |=> mode_reg == $past(addr);
    endproperty
    a_base_load: assert property (p_base_load) // RULE19
        else $error("base mode register not loaded");

    property p_ext_load;
        @(posedge clk) disable iff (sys_rst)
        load_ext && !deep_power_down |=> drive_strength == $past(addr[7:5]);
    endproperty
    a_ext_load: assert property (p_ext_load) // RULE13
        else $error("extended register load missed");

    property p_block_stay;
        @(posedge clk) disable iff (sys_rst)
        burst_valid && $past(burst_valid) && !$past(cmd_col)
            |-> (burst_col & ~col_mask) == ($past(burst_col) & ~col_mask);
    endproperty
    a_block_stay: assert property (p_block_stay) // RULE7
        else $error("burst left its block");

    property p_seq_step;
        @(posedge clk) disable iff (sys_rst)
        burst_valid && !interleaved && !last && !cmd_col && !deep_power_down
            |=> (burst_col[3:0] & $past(off_mask)) ==
                (4'($past(burst_col[3:0]) + 4'h1) & $past(off_mask));
    endproperty
    a_seq_step: assert property (p_seq_step) // RULE8
        else $error("sequential step wrong");

    property p_int_step;
        @(posedge clk) disable iff (sys_rst)
        burst_valid && interleaved
            |-> (burst_col[3:0] & off_mask) == (start_reg ^ cnt_reg);
    endproperty
    a_int_step: assert property (p_int_step) // RULE9
        else $error("interleaved offset wrong");

    property p_cl3;
        @(posedge clk) disable iff (sys_rst)
        cmd_rd && bl_ok && cl_code == lpddr_cfg_pkg::CL_CODE_3 && !load_base
            ##0 !deep_power_down
            |-> !rd_first_data ##1 !rd_first_data ##1 rd_first_data;
    endproperty
    a_cl3: assert property (p_cl3) // RULE11
        else $error("latency three timing wrong");

    property p_cl2;
        @(posedge clk) disable iff (sys_rst)
        cmd_rd && bl_ok && cl_code == lpddr_cfg_pkg::CL_CODE_2 && !load_base
            && !deep_power_down |=> rd_first_data;
    endproperty
    a_cl2: assert property (p_cl2) // RULE12
        else $error("latency two timing wrong");

    property p_sr_gate;
        @(posedge clk) disable iff (sys_rst)
        !self_refresh |-> partial_refresh_region == 3'h0 &&
                          temp_comp_refresh_setting == 2'h0;
    endproperty
    a_sr_gate: assert property (p_sr_gate) // RULE17
        else $error("refresh setting active outside self refresh");

    property p_bl2_len;
        @(posedge clk) disable iff (sys_rst)
        cmd_col && bl_code == lpddr_cfg_pkg::BL_CODE_2 && !deep_power_down
            ##1 !cmd_col [*2] |=> !burst_valid;
    endproperty
    a_bl2_len: assert property (p_bl2_len) // RULE1
        else $error("length two burst did not end");

    property p_start_col;
        @(posedge clk) disable iff (sys_rst)
        cmd_col && bl_ok && !deep_power_down
            |=> burst_valid && burst_col == $past(addr[CW-1:0]);
    endproperty
    a_start_col: assert property (p_start_col) // RULE3
        else $error("burst did not start at column");

    c_read: cover property (@(posedge clk) disable iff (sys_rst)
        rd_first_data);
    c_intl8: cover property (@(posedge clk) disable iff (sys_rst)
        burst_valid && interleaved && off_mask == 4'h7 && last);
    c_sr: cover property (@(posedge clk) disable iff (sys_rst)
        self_refresh && partial_refresh_region != 3'h0);
endmodule
`default_nettype wire

//--- hw/lpddr_cfg_pkg.sv
`default_nettype none
package lpddr_cfg_pkg;
    // Address and register widths, register reset values
    localparam int          ADDR_W         = 13;
    localparam int          COL_W          = 10;
    localparam int          OFF_W          = 4;
    localparam logic [12:0] MODE_RST       = 13'h0000;
    localparam logic [12:0] EXT_RST        = 13'h0000;

    // Base mode register fields
    localparam int          BL_LSB         = 0;
    localparam int          BT_BIT         = 3;
    localparam int          CL_LSB         = 4;
    localparam logic [2:0]  BL_CODE_2      = 3'h1;
    localparam logic [2:0]  BL_CODE_4      = 3'h2;
    localparam logic [2:0]  BL_CODE_8      = 3'h3;
    localparam logic [2:0]  BL_CODE_16     = 3'h4;
    localparam logic [3:0]  OFF_MASK_2     = 4'h1;
    localparam logic [3:0]  OFF_MASK_4     = 4'h3;
    localparam logic [3:0]  OFF_MASK_8     = 4'h7;
    localparam logic [3:0]  OFF_MASK_16    = 4'hF;
    localparam logic [2:0]  CL_CODE_2      = 3'h2;
    localparam logic [2:0]  CL_CODE_3      = 3'h3;
    localparam logic [2:0]  CL_CODE_4      = 3'h4;

    // Extended mode register fields
    localparam int          REGION_LSB     = 0;
    localparam int          TEMP_LSB       = 3;
    localparam int          DRV_LSB        = 5;
    localparam logic [2:0]  REGION_OFF     = 3'h0;
    localparam logic [1:0]  TEMP_OFF       = 2'h0;

    // Bank select values choosing the target mode register
    localparam logic [1:0]  BANK_BASE_MODE = 2'h0;
    localparam logic [1:0]  BANK_EXT_MODE  = 2'h2;

    typedef enum logic {BURST_IDLE, BURST_RUN} burst_state_t;
endpackage
`default_nettype wire

//--- tb/lpddr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory controller on the far side: issues commands on the pins
module lpddr_ctrl_model #(
    parameter int MODE_LOAD_WAIT = 2
) (
    input  wire logic        clk,
    output var  logic        cs_n,
    output var  logic        ras_n,
    output var  logic        cas_n,
    output var  logic        we_n,
    output var  logic        bank_sel_low,
    output var  logic        bank_sel_high,
    output var  logic [12:0] addr
);
    // Pins start deselected
    initial begin
        cs_n = 1'b1;
        ras_n = 1'b1;
        cas_n = 1'b1;
        we_n = 1'b1;
        {bank_sel_high, bank_sel_low} = 2'h0;
        addr = 13'h0000;
    end

    // Kind 0 mode write, 1 read, 2 write; held through the sampling edge
    task automatic issue(input int kind, input logic [1:0] bank,
                         input logic [12:0] a);
        @(posedge clk);
        cs_n <= 1'b0;
        ras_n <= (kind != 0);
        cas_n <= 1'b0;
        we_n <= (kind == 1);
        {bank_sel_high, bank_sel_low} <= bank;
        addr <= a;
        @(posedge clk);
        cs_n <= 1'b1;
        addr <= ~a;
        // Quiet period after a mode write, issued only while idle
        if (kind == 0) begin
            repeat (MODE_LOAD_WAIT) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

//--- tb/lpddr_burst_order_and_mode_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr_burst_order_and_mode_config_bench;
    logic        clk, sys_rst, cs_n, ras_n, cas_n, we_n, bsl, bsh;
    logic        self_refresh, deep_power_down;
    logic [12:0] addr;
    logic [9:0]  burst_col;
    logic        burst_valid, burst_is_write, rd_first_data;
    logic [2:0]  region, drv;
    logic [1:0]  temp;
    int          miscompares = 0;
    int          tests_run = 0;

    lpddr_ctrl_model m (.clk(clk), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_sel_low(bsl),
        .bank_sel_high(bsh), .addr(addr));

    lpddr_burst_mode #(.SUPPORT_BL16(1'b1)) dut (.clk(clk),
        .sys_rst(sys_rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank_sel_low(bsl), .bank_sel_high(bsh),
        .addr(addr), .self_refresh(self_refresh),
        .deep_power_down(deep_power_down), .burst_col(burst_col),
        .burst_valid(burst_valid), .burst_is_write(burst_is_write),
        .rd_first_data(rd_first_data), .partial_refresh_region(region),
        .temp_comp_refresh_setting(temp), .drive_strength(drv));

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, msg, got, exp);
        end
    endtask

    // Program length, type and latency, then run one column command
    task automatic burst(input logic [2:0] blc, input int bl, input logic bt,
                         input logic [2:0] cl, input logic [9:0] col,
                         input logic wr);
        logic [9:0] mask;
        logic [9:0] e;
        mask = 10'(bl - 1);
        m.issue(0, 2'h0, {6'h00, cl, bt, blc});
        m.issue(wr ? 2 : 1, 2'h0, {3'h0, col});
        for (int k = 1; k <= bl + 1; k++) begin
            #1;
            if (k <= bl) begin
                e = bt ? ((col & mask) ^ 10'(k - 1))
                       : ((col + 10'(k - 1)) & mask);
                chk(burst_col, (col & ~mask) | e, "column");
                chk({9'h0, burst_is_write}, {9'h0, wr}, "dir");
            end
            chk({9'h0, burst_valid}, {9'h0, k <= bl}, "valid");
            chk({9'h0, rd_first_data}, {9'h0, !wr && k == int'(cl) - 1},
                "first data");
            @(posedge clk);
        end
    endtask

    // Extended register fields, self refresh gating, bank and power down
    task automatic ext_mode();
        m.issue(0, 2'h2, 13'h0049);
        chk({7'h0, drv}, 10'h002, "drive");
        chk({7'h0, region}, 10'h000, "region gated");
        chk({8'h0, temp}, 10'h000, "temp gated");
        self_refresh <= 1'b1;
        @(posedge clk);
        #1;
        chk({7'h0, region}, 10'h001, "region");
        chk({8'h0, temp}, 10'h001, "temp");
        m.issue(0, 2'h1, 13'h0060);
        chk({7'h0, drv}, 10'h002, "drive kept");
        deep_power_down <= 1'b1;
        @(posedge clk);
        deep_power_down <= 1'b0;
        @(posedge clk);
        self_refresh <= 1'b0;
        #1;
        chk({7'h0, drv}, 10'h000, "drive cleared");
    endtask

    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        self_refresh = 1'b0;
        deep_power_down = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        burst(3'h3, 8, 1'b0, 3'h3, 10'h00D, 1'b0);
        burst(3'h2, 4, 1'b1, 3'h2, 10'h3F6, 1'b1);
        burst(3'h2, 4, 1'b1, 3'h2, 10'h3F5, 1'b0);
        burst(3'h1, 2, 1'b0, 3'h4, 10'h0C1, 1'b0);
        burst(3'h1, 2, 1'b1, 3'h3, 10'h0C0, 1'b1);
        burst(3'h4, 16, 1'b1, 3'h3, 10'h2A5, 1'b0);
        burst(3'h4, 16, 1'b0, 3'h3, 10'h13E, 1'b0);
        burst(3'h3, 8, 1'b1, 3'h2, 10'h1FB, 1'b1);
        ext_mode();
        finish_test();
    end
endmodule
`default_nettype wire
